// ### design/dsp_cfg_pkg.sv
package dsp_cfg_pkg;
  localparam int NUM_REGS = 10;
  localparam int SAMPLE_W = 14;
  localparam int IDX_W = 9;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TEST = 9'h00d;
  localparam logic [IDX_W-1:0] IDX_OFFSET = 9'h010;
  localparam logic [IDX_W-1:0] IDX_OUTMODE = 9'h014;
  localparam logic [IDX_W-1:0] IDX_CLKPHASE = 9'h016;
  localparam logic [IDX_W-1:0] IDX_DCO_DELAY = 9'h017;
  localparam logic [IDX_W-1:0] IDX_REFSPAN = 9'h018;
  localparam logic [IDX_W-1:0] IDX_SYNC = 9'h100;
  localparam logic [IDX_W-1:0] IDX_MIX = 9'h101;
  localparam logic [IDX_W-1:0] IDX_FIR = 9'h102;
  localparam logic [IDX_W-1:0] IDX_FILTER = 9'h103;
  localparam logic [IDX_W-1:0] IDX_STATUS = 9'h1f0;

  // Slot numbers in the register array
  localparam int SLOT_TEST = 0;
  localparam int SLOT_OFFSET = 1;
  localparam int SLOT_OUTMODE = 2;
  localparam int SLOT_CLKPHASE = 3;
  localparam int SLOT_DCO_DELAY = 4;
  localparam int SLOT_REFSPAN = 5;
  localparam int SLOT_SYNC = 6;
  localparam int SLOT_MIX = 7;
  localparam int SLOT_FIR = 8;
  localparam int SLOT_FILTER = 9;

  localparam logic [IDX_W-1:0] REG_IDX [NUM_REGS] = '{IDX_TEST, IDX_OFFSET, IDX_OUTMODE,
    IDX_CLKPHASE, IDX_DCO_DELAY, IDX_REFSPAN, IDX_SYNC, IDX_MIX, IDX_FIR, IDX_FILTER};
  localparam logic [7:0] REG_RST [NUM_REGS] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hc0, 8'h00, 8'h00, 8'h00, 8'h01};
  // Writable bits; open bits keep their reset value
  localparam logic [7:0] REG_WMASK [NUM_REGS] = '{8'h37, 8'h3f, 8'hf7, 8'h87, 8'h1f,
    8'hc0, 8'hff, 8'h33, 8'h0f, 8'h0e};

  // Field positions
  localparam int TP_MODE_LSB = 0;
  localparam int TP_RST_SHORT_BIT = 4;
  localparam int TP_RST_LONG_BIT = 5;
  localparam int OFS_LSB = 0;
  localparam int OFS_W = 6;
  localparam int OM_FMT_LSB = 0;
  localparam int OM_INVERT_BIT = 2;
  localparam int OM_OE_BAR_BIT = 4;
  localparam int OM_INTERLEAVE_BIT = 5;
  localparam int OM_LVDS_BIT = 6;
  localparam int OM_DRIVE_BIT = 7;
  localparam int CP_PHASE_LSB = 0;
  localparam int CP_DCO_INV_BIT = 7;
  localparam int DCO_DLY_LSB = 0;
  localparam int DCO_DLY_W = 5;
  localparam int REF_LSB = 6;
  localparam int MIX_NEXT_BIT = 1;
  localparam int MIX_EN_BIT = 0;
  localparam int MIX_START_LSB = 4;
  localparam int FIR_EN_BIT = 0;
  localparam int FIR_COMPLEX_BIT = 1;
  localparam int FIR_MIX_DIS_BIT = 2;
  localparam int FIR_GAIN_BIT = 3;
  localparam int FLT_HP_BIT = 1;
  localparam int FLT_REV_BIT = 2;
  localparam int FLT_PHASE_BIT = 3;

  typedef enum logic [2:0] {
    TP_OFF = 3'h0,
    TP_MIDSCALE = 3'h1,
    TP_POS_FULL_SCALE = 3'h2,
    TP_NEG_FULL_SCALE = 3'h3,
    TP_CHECKER = 3'h4,
    TP_PSEUDORANDOM_LONG = 3'h5,
    TP_PSEUDORANDOM_SHORT = 3'h6,
    TP_WORD_TOGGLE = 3'h7
  } test_mode_t;

  typedef enum logic [1:0] {
    FMT_OFFSET_BIN = 2'h0,
    FMT_TWOS = 2'h1,
    FMT_GRAY = 2'h2,
    FMT_OFFSET_BIN_ALT = 2'h3
  } out_fmt_t;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [SAMPLE_W-1:0] PAT_MIDSCALE = 14'h2000;
  localparam logic [SAMPLE_W-1:0] PAT_POS_FULL_SCALE = 14'h3fff;
  localparam logic [SAMPLE_W-1:0] PAT_NEG_FULL_SCALE = 14'h0000;
  localparam logic [SAMPLE_W-1:0] PAT_CHECKER = 14'h2aaa;
  localparam logic [22:0] PN_LONG_SEED = 23'h7fffff;
  localparam logic [8:0] PN_SHORT_SEED = 9'h1ff;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 14'h1fff;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MIN = 14'h2000;
endpackage

// ### design/test_pattern_gen.sv
`timescale 1ns/1ps
`default_nettype none
module test_pattern_gen
  import dsp_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] mode,
  input wire logic advance,
  input wire logic reset_long,
  input wire logic reset_short,
  output logic [SAMPLE_W-1:0] pattern
);
  logic [22:0] long_q, long_d;
  logic [8:0] short_q, short_d;
  logic toggle_q, toggle_d;

  always_comb begin
    long_d = long_q;
    short_d = short_q;
    toggle_d = toggle_q;
    // Sequences step only on sample strobes so the pattern tracks the output rate
    if (advance) begin
      long_d = {long_q[21:0], long_q[22] ^ long_q[17]};
      short_d = {short_q[7:0], short_q[8] ^ short_q[4]};
      toggle_d = ~toggle_q;
    end
    // Held at the seed while the reset bits stay set
    if (reset_long) begin
      long_d = PN_LONG_SEED;
    end
    if (reset_short) begin
      short_d = PN_SHORT_SEED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      long_q <= PN_LONG_SEED;
      short_q <= PN_SHORT_SEED;
      toggle_q <= 1'b0;
    end else begin
      long_q <= long_d;
      short_q <= short_d;
      toggle_q <= toggle_d;
    end
  end

  always_comb begin
    unique case (test_mode_t'(mode))
      TP_OFF: pattern = '0;
      TP_MIDSCALE: pattern = PAT_MIDSCALE;
      TP_POS_FULL_SCALE: pattern = PAT_POS_FULL_SCALE;
      TP_NEG_FULL_SCALE: pattern = PAT_NEG_FULL_SCALE;
      TP_CHECKER: pattern = toggle_q ? ~PAT_CHECKER : PAT_CHECKER;
      TP_PSEUDORANDOM_LONG: pattern = long_q[SAMPLE_W-1:0];
      TP_PSEUDORANDOM_SHORT: pattern = {short_q[4:0], short_q};
      TP_WORD_TOGGLE: pattern = toggle_q ? PAT_POS_FULL_SCALE : PAT_NEG_FULL_SCALE;
    endcase
  end
endmodule
`default_nettype wire

// ### design/dsp_cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_cfg_regs
  import dsp_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [10:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [10:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_strobe,
  input wire logic [SAMPLE_W-1:0] sample_a,
  input wire logic [SAMPLE_W-1:0] sample_b,
  output logic [SAMPLE_W-1:0] data_a,
  output logic [SAMPLE_W-1:0] data_b,
  output logic data_out_enable,
  output logic divider_strobe,
  output logic drive_reduced,
  output logic output_lvds,
  output logic output_interleaved,
  output logic data_clock_out_invert,
  output logic [DCO_DLY_W-1:0] data_clock_out_delay,
  output logic [1:0] reference_span,
  output logic [7:0] sync_enables,
  output logic mix_sync_enable,
  output logic mix_next_sync_only,
  output logic [1:0] mix_start_state,
  output logic mix_disable,
  output logic complex_output_enable,
  output logic fir_filter_enable,
  output logic highpass_select,
  output logic spectral_reversal,
  output logic halfband_phase
);
  logic [7:0] reg_q [NUM_REGS];
  logic [7:0] reg_d [NUM_REGS];
  logic [IDX_W-1:0] awidx_q, awidx_d;
  logic aw_held_q, aw_held_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wen_q, wen_d;
  logic w_held_q, w_held_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [6:0] strobe_line_q, strobe_line_d;
  logic [7:0] strobe_taps;
  logic strobe_del;
  logic [SAMPLE_W-1:0] ch_in [2];
  logic [SAMPLE_W-1:0] ch_out [2];

  function automatic int find_slot(input logic [IDX_W-1:0] idx);
    int slot;
    slot = -1;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_IDX[i] == idx) begin
        slot = i;
      end
    end
    return slot;
  endfunction

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_comb begin
    int slot;
    slot = -1;
    reg_d = reg_q;
    awidx_d = awidx_q;
    aw_held_d = aw_held_q;
    wbyte_d = wbyte_q;
    wen_d = wen_q;
    w_held_d = w_held_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awidx_d = s_axi_awaddr[10:2];
      aw_held_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wbyte_d = s_axi_wdata[7:0];
      wen_d = s_axi_wstrb[0];
      w_held_d = 1'b1;
    end
    // Write commits once both halves are held, answered the same edge
    if (aw_held_q && w_held_q) begin
      slot = find_slot(awidx_q);
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (slot < 0) ? RESP_SLVERR : RESP_OKAY;
      if (slot >= 0 && wen_q) begin
        reg_d[slot] = (wbyte_q & REG_WMASK[slot]) | (reg_q[slot] & ~REG_WMASK[slot]);
      end
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      slot = find_slot(s_axi_araddr[10:2]);
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      if (slot >= 0) begin
        rdata_d = {24'h000000, reg_q[slot]};
      end else if (s_axi_araddr[10:2] == IDX_STATUS) begin
        rdata_d = {29'h0000000, strobe_del, reg_q[SLOT_TEST][2:0] != 3'h0,
          data_out_enable};
      end else begin
        rresp_d = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_q <= REG_RST;
      awidx_q <= '0;
      aw_held_q <= 1'b0;
      wbyte_q <= 8'h00;
      wen_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else begin
      reg_q <= reg_d;
      awidx_q <= awidx_d;
      aw_held_q <= aw_held_d;
      wbyte_q <= wbyte_d;
      wen_q <= wen_d;
      w_held_q <= w_held_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  // Tap zero is the undelayed strobe, tap n is n clocks late
  assign strobe_line_d = {strobe_line_q[5:0], sample_strobe};
  assign strobe_taps = {strobe_line_q, sample_strobe};
  assign strobe_del = strobe_taps[reg_q[SLOT_CLKPHASE][CP_PHASE_LSB +: 3]];
  assign divider_strobe = strobe_del;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_line_q <= 7'h00;
    end else begin
      strobe_line_q <= strobe_line_d;
    end
  end

  assign ch_in[0] = sample_a;
  assign ch_in[1] = sample_b;
  assign data_a = ch_out[0];
  assign data_b = ch_out[1];

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [SAMPLE_W-1:0] out_q, out_d;
    logic [SAMPLE_W-1:0] pattern;
    logic signed [SAMPLE_W+1:0] gained;
    logic signed [SAMPLE_W+1:0] summed;
    logic [SAMPLE_W-1:0] sat;
    logic [SAMPLE_W-1:0] obin;
    logic [SAMPLE_W-1:0] fmt;

    test_pattern_gen i_test_pattern_gen (
      .aclk(aclk),
      .aresetn(aresetn),
      .mode(reg_q[SLOT_TEST][TP_MODE_LSB +: 3]),
      .advance(strobe_del),
      .reset_long(reg_q[SLOT_TEST][TP_RST_LONG_BIT]),
      .reset_short(reg_q[SLOT_TEST][TP_RST_SHORT_BIT]),
      .pattern(pattern)
    );

    always_comb begin
      gained = {{2{ch_in[ch][SAMPLE_W-1]}}, ch_in[ch]};
      // Gain stage sits ahead of the offset so saturation happens once
      if (reg_q[SLOT_FIR][FIR_EN_BIT] && !reg_q[SLOT_FIR][FIR_GAIN_BIT]) begin
        gained = gained <<< 1;
      end
      summed = gained + {{(SAMPLE_W+2-OFS_W){reg_q[SLOT_OFFSET][OFS_LSB+OFS_W-1]}},
        reg_q[SLOT_OFFSET][OFS_LSB +: OFS_W]};
      if (summed > $signed({2'b00, SAMPLE_MAX})) begin
        sat = SAMPLE_MAX;
      end else if (summed < $signed({2'b11, SAMPLE_MIN})) begin
        sat = SAMPLE_MIN;
      end else begin
        sat = summed[SAMPLE_W-1:0];
      end
      obin = {~sat[SAMPLE_W-1], sat[SAMPLE_W-2:0]};
      unique case (out_fmt_t'(reg_q[SLOT_OUTMODE][OM_FMT_LSB +: 2]))
        FMT_TWOS: fmt = sat;
        FMT_GRAY: fmt = obin ^ (obin >> 1);
        FMT_OFFSET_BIN, FMT_OFFSET_BIN_ALT: fmt = obin;
      endcase
      if (reg_q[SLOT_OUTMODE][OM_INVERT_BIT]) begin
        fmt = ~fmt;
      end
      out_d = out_q;
      if (strobe_del) begin
        // Pattern words bypass offset, gain and formatting
        out_d = (reg_q[SLOT_TEST][2:0] != 3'h0) ? pattern : fmt;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        out_q <= '0;
      end else begin
        out_q <= out_d;
      end
    end

    assign ch_out[ch] = out_q;
  end

  assign data_out_enable = !reg_q[SLOT_OUTMODE][OM_OE_BAR_BIT];
  assign drive_reduced = reg_q[SLOT_OUTMODE][OM_DRIVE_BIT];
  assign output_lvds = reg_q[SLOT_OUTMODE][OM_LVDS_BIT];
  assign output_interleaved = reg_q[SLOT_OUTMODE][OM_INTERLEAVE_BIT];
  assign data_clock_out_invert = reg_q[SLOT_CLKPHASE][CP_DCO_INV_BIT];
  assign data_clock_out_delay = reg_q[SLOT_DCO_DELAY][DCO_DLY_LSB +: DCO_DLY_W];
  assign reference_span = reg_q[SLOT_REFSPAN][REF_LSB +: 2];
  assign sync_enables = reg_q[SLOT_SYNC];
  assign mix_sync_enable = reg_q[SLOT_MIX][MIX_EN_BIT];
  assign mix_next_sync_only = reg_q[SLOT_MIX][MIX_NEXT_BIT];
  assign mix_start_state = reg_q[SLOT_MIX][MIX_START_LSB +: 2];
  assign mix_disable = reg_q[SLOT_FIR][FIR_MIX_DIS_BIT];
  assign complex_output_enable = reg_q[SLOT_FIR][FIR_COMPLEX_BIT];
  assign fir_filter_enable = reg_q[SLOT_FIR][FIR_EN_BIT];
  assign highpass_select = reg_q[SLOT_FILTER][FLT_HP_BIT];
  assign spectral_reversal = reg_q[SLOT_FILTER][FLT_REV_BIT];
  assign halfband_phase = reg_q[SLOT_FILTER][FLT_PHASE_BIT];
endmodule
`default_nettype wire

// ### sim/dsp_cfg_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_cfg_regs_assertions
  import dsp_cfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [10:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_strobe,
  input wire logic [SAMPLE_W-1:0] data_a,
  input wire logic [SAMPLE_W-1:0] data_b,
  input wire logic divider_strobe
);
  // Shadow of the fields under check, committed on the same edge as the design
  logic ah_q, wh_q, ws_q, exp_strobe;
  logic [8:0] ai_q;
  logic [7:0] wd_q;
  logic [2:0] ph_q, tp_q;
  logic [6:0] sh_q;
  always_comb exp_strobe = (ph_q == 3'h0) ? sample_strobe : sh_q[ph_q - 3'h1];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ah_q <= 1'b0;
      wh_q <= 1'b0;
      ph_q <= 3'h0;
      tp_q <= 3'h0;
      sh_q <= 7'h00;
    end else begin
      sh_q <= {sh_q[5:0], sample_strobe};
      if (s_axi_awvalid && s_axi_awready) begin
        ah_q <= 1'b1;
        ai_q <= s_axi_awaddr[10:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wh_q <= 1'b1;
        wd_q <= s_axi_wdata[7:0];
        ws_q <= s_axi_wstrb[0];
      end
      if (ah_q && wh_q) begin
        ah_q <= 1'b0;
        wh_q <= 1'b0;
        if (ws_q && ai_q == IDX_CLKPHASE) ph_q <= wd_q[2:0];
        if (ws_q && ai_q == IDX_TEST) tp_q <= wd_q[2:0];
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    ah_q && wh_q;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  strobe_delay_a: assert property (divider_strobe == exp_strobe)
    else $error("divider strobe delay wrong");
  pat_mid_a: assert property (divider_strobe && tp_q == 3'h1 |=> data_a == PAT_MIDSCALE)
    else $error("midscale pattern wrong");
  pat_full_a: assert property (divider_strobe && tp_q == 3'h2 |=>
    data_a == PAT_POS_FULL_SCALE && data_b == PAT_POS_FULL_SCALE)
    else $error("full scale pattern not on outputs");
  wr_resp_a: assert property (wr_both |=> s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
endmodule
bind dsp_cfg_regs dsp_cfg_regs_assertions i_dsp_cfg_regs_assertions (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sample_strobe, .data_a, .data_b,
  .divider_strobe);
`default_nettype wire

// ### sim/dsp_cfg_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dsp_cfg_regs_tb_top
  import dsp_cfg_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sample_strobe = 1'b0;
  logic [10:0] s_axi_awaddr = 11'h000, s_axi_araddr = 11'h000;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [SAMPLE_W-1:0] sample_a = 14'h0000, sample_b = 14'h0000, data_a, data_b;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, reference_span, mix_start_state, rr;
  logic [DCO_DLY_W-1:0] data_clock_out_delay;
  logic [7:0] sync_enables;
  logic data_out_enable, divider_strobe, drive_reduced, output_lvds, output_interleaved;
  logic data_clock_out_invert, mix_sync_enable, mix_next_sync_only, mix_disable;
  logic complex_output_enable, fir_filter_enable, highpass_select, spectral_reversal;
  logic halfband_phase;
  int error_cnt = 0, n_checks = 0;
  dsp_cfg_regs i_dsp_cfg_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sample_strobe, .sample_a, .sample_b, .data_a, .data_b,
    .data_out_enable, .divider_strobe, .drive_reduced, .output_lvds, .output_interleaved,
    .data_clock_out_invert, .data_clock_out_delay, .reference_span, .sync_enables,
    .mix_sync_enable, .mix_next_sync_only, .mix_start_state, .mix_disable,
    .complex_output_enable, .fir_filter_enable, .highpass_select, .spectral_reversal,
    .halfband_phase);
  always #12.5 aclk = ~aclk;
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Ready is looked at on the falling edge so the handshake edge itself is race free
  task automatic wr(input logic [8:0] i, input logic [7:0] d);
    logic a, w;
    @(posedge aclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !a) || (s_axi_wvalid && !w));
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] i);
    @(posedge aclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input logic [SAMPLE_W-1:0] s);
    @(posedge aclk);
    sample_a <= s;
    sample_b <= s;
    sample_strobe <= 1'b1;
    @(posedge aclk);
    sample_strobe <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic t_reset;
    for (int k = 0; k < NUM_REGS; k++) begin
      rd(REG_IDX[k]);
      chk(rv, {24'h000000, REG_RST[k]});
    end
    rd(9'h00e);
    chk({rv[1:0], rr}, {2'h0, RESP_SLVERR});
    chk({data_out_enable, reference_span}, 32'h7);
    $display("test reset done");
  endtask
  task automatic t_access;
    for (int k = 0; k < NUM_REGS; k++) begin
      wr(REG_IDX[k], 8'hff);
      chk(rr, RESP_OKAY);
      rd(REG_IDX[k]);
      chk(rv, {24'h000000, REG_RST[k] | REG_WMASK[k]});
      if (k == SLOT_OUTMODE) chk(data_out_enable, 32'h0);
      wr(REG_IDX[k], REG_RST[k]);
    end
    // Every register-driven pin but data_out_enable seen set, then back at its reset level
    for (int k = 0; k < NUM_REGS; k++) begin
      wr(REG_IDX[k], 8'hff);
    end
    chk({drive_reduced, output_lvds, output_interleaved, data_out_enable, data_clock_out_invert,
      data_clock_out_delay, reference_span, sync_enables}, 32'h000effff);
    chk({mix_sync_enable, mix_next_sync_only, mix_start_state, mix_disable,
      complex_output_enable, fir_filter_enable, highpass_select, spectral_reversal,
      halfband_phase}, 32'h000003ff);
    for (int k = 0; k < NUM_REGS; k++) begin
      wr(REG_IDX[k], REG_RST[k]);
    end
    chk({drive_reduced, output_lvds, output_interleaved, data_out_enable, data_clock_out_invert,
      data_clock_out_delay, reference_span, sync_enables}, 32'h00010300);
    chk({mix_sync_enable, mix_next_sync_only, mix_start_state, mix_disable,
      complex_output_enable, fir_filter_enable, highpass_select, spectral_reversal,
      halfband_phase}, 32'h00000000);
    // Byte lane zero off: write answered but register untouched
    @(posedge aclk);
    s_axi_wstrb <= 4'h0;
    wr(IDX_SYNC, 8'h5a);
    chk(rr, RESP_OKAY);
    rd(IDX_SYNC);
    chk(rv, 32'h00000000);
    @(posedge aclk);
    s_axi_wstrb <= 4'h1;
    wr(IDX_STATUS, 8'h00);
    chk(rr, RESP_SLVERR);
    wr(9'h00e, 8'h00);
    chk(rr, RESP_SLVERR);
    $display("test access done");
  endtask
  task automatic t_pattern;
    logic [SAMPLE_W-1:0] p;
    logic [SAMPLE_W-1:0] fix [4] = '{14'h0000, PAT_MIDSCALE, PAT_POS_FULL_SCALE,
      PAT_NEG_FULL_SCALE};
    for (int m = 1; m < 8; m++) begin
      wr(IDX_TEST, 8'(m));
      if (m == 1) begin
        rd(IDX_STATUS);
        chk(rv, 32'h00000003);
      end
      pulse(14'h0123);
      p = data_a;
      pulse(14'h0123);
      chk(data_b, data_a);
      if (m < 4) chk(data_a, fix[m]);
      else if (m != 4 && m != 7) chk(data_a == p || data_a == 14'h2123, 32'h0);
      else chk(data_a ^ p, 14'h3fff);
      if (m == 4) chk(data_a == PAT_CHECKER || p == PAT_CHECKER, 32'h1);
      if (m == 7) chk(data_a == 14'h0000 || p == 14'h0000, 32'h1);
    end
    // Long sequence held at its seed while its reset bit stays set
    wr(IDX_TEST, 8'h25);
    pulse(14'h0123);
    p = data_a;
    pulse(14'h0123);
    chk(p, PN_LONG_SEED[SAMPLE_W-1:0]);
    chk(data_a, PN_LONG_SEED[SAMPLE_W-1:0]);
    wr(IDX_TEST, 8'h00);
    pulse(14'h0123);
    chk(data_a, 14'h2123);
    $display("test pattern done");
  endtask
  task automatic t_offset;
    wr(IDX_OUTMODE, 8'h01);
    wr(IDX_OFFSET, 8'h20);
    pulse(14'h0100);
    chk(data_a, 14'h00e0);
    pulse(SAMPLE_MIN);
    chk(data_b, SAMPLE_MIN);
    wr(IDX_OFFSET, 8'h1f);
    pulse(SAMPLE_MAX);
    chk(data_a, SAMPLE_MAX);
    pulse(14'h3ff0);
    chk(data_a, 14'h000f);
    wr(IDX_OFFSET, 8'h00);
    wr(IDX_OUTMODE, 8'h02);
    pulse(14'h0123);
    chk(data_a, 14'h31b2);
    wr(IDX_OUTMODE, 8'h07);
    pulse(14'h0123);
    chk(data_a, 14'h1edc);
    wr(IDX_OUTMODE, 8'h01);
    $display("test offset done");
  endtask
  task automatic t_gain;
    logic [7:0] cfg [3] = '{8'h01, 8'h09, 8'h00};
    logic [SAMPLE_W-1:0] ex [3] = '{14'h0246, 14'h0123, 14'h0123};
    for (int k = 0; k < 3; k++) begin
      wr(IDX_FIR, cfg[k]);
      pulse(14'h0123);
      chk(data_a, ex[k]);
    end
    wr(IDX_FIR, 8'h01);
    pulse(14'h1000);
    chk(data_a, SAMPLE_MAX);
    $display("test gain done");
  endtask
  task automatic t_phase;
    int n;
    for (int p = 0; p < 8; p++) begin
      wr(IDX_CLKPHASE, 8'(p));
      @(posedge aclk);
      sample_strobe <= 1'b1;
      n = 0;
      #1;
      while (divider_strobe !== 1'b1 && n < 20) begin
        @(posedge aclk);
        sample_strobe <= 1'b0;
        n++;
        #1;
      end
      // Strobe already dropped on a clock edge inside the loop when n is nonzero
      if (n == 0) begin
        @(posedge aclk);
        sample_strobe <= 1'b0;
      end
      chk(32'(n), 32'(p));
      repeat (10) @(posedge aclk);
    end
    $display("test phase done");
  endtask
  // Whole run is under a thousand cycles; the limit leaves a wide margin
  initial begin
    #500000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_access;
    t_pattern;
    t_offset;
    t_gain;
    t_phase;
    test_done;
  end
endmodule
`default_nettype wire
